// >>> logic/ohd_defines.svh
// constants for the sync delay and meshing block
// assumes inclusion by bare name from the package and modules
`ifndef OHD_DEFINES_SVH
`define OHD_DEFINES_SVH
`define OHD_ADDR_HDELAY 8'hc6
`define OHD_ADDR_OVCTRL 8'hc0
`define OHD_HDELAY_RESET 8'h00
`define OHD_OVCTRL_RESET 8'h00
`define OHD_CODE_W 4
`define OHD_DELAY_STEP 32
`define OHD_STEP_SHIFT 5
`define OHD_CELL_DOTS 12
`define OHD_ROW_LINES 18
`define OHD_BIT_FRAME_MODE 5
`define OHD_BIT_MESH_EN 6
`endif

// >>> logic/ohd_pkg.sv
// types shared by the sync delay and meshing block
// assumes the defines header is on the include path
package ohd_pkg;
`include "ohd_defines.svh"
   typedef struct packed
   {
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ohd_reg_req_t;
   typedef struct packed
   {
      logic active;
      logic bg_en;
      logic fg_dot;
   } ohd_pix_t;
   typedef enum logic [1:0]
   {
      OHD_IDLE = 2'b00,
      OHD_WAIT = 2'b01,
      OHD_RUN = 2'b10
   } ohd_state_t;
endpackage

// >>> logic/ohd_delay.sv
// hsync delay counter: fires one pulse after code*32 dots
// assumes a clean one-cycle sync edge pulse on the same clock
`timescale 1ns/1ps
`include "ohd_defines.svh"
module ohd_delay
   import ohd_pkg::*;
#(
   parameter int CODE_W = 4
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic edge_pulse,
   input wire logic [CODE_W-1:0] code,
   output logic fire
);
   localparam int CNT_W = CODE_W + `OHD_STEP_SHIFT;
   initial
   begin
      if (CODE_W < 1 || CODE_W > 8)
         $error("ohd_delay: CODE_W out of range");
   end
   ohd_state_t state;
   logic [CNT_W-1:0] cnt;
   // code held from the sync edge, a write mid-wait must not move the target
   logic [CODE_W-1:0] code_q;
   wire logic [CNT_W-1:0] target = {code_q, `OHD_STEP_SHIFT'(0)};
   wire logic done = (cnt == target - CNT_W'(1));
   // =====================================================
   // delay sequencer
   // count from sync edge
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state <= OHD_IDLE;
         cnt <= '0;
         code_q <= '0;
         fire <= 1'b0;
      end
      else
      begin
         fire <= 1'b0;
         unique case (state)
            OHD_IDLE:
            begin
               if (edge_pulse)
               begin
                  cnt <= '0;
                  code_q <= code;
                  if (code == '0)
                     fire <= 1'b1;
                  else
                     state <= OHD_WAIT;
               end
            end
            OHD_WAIT:
            begin
               cnt <= cnt + CNT_W'(1);
               if (done)
               begin
                  fire <= 1'b1;
                  state <= OHD_IDLE;
               end
            end
            default:
               state <= OHD_IDLE;
         endcase
      end
   end
   a_delay_bound: assert property (@(posedge clk) disable iff (rst)
      state == OHD_WAIT |-> cnt < target)
      else $error("delay count ran past target");
endmodule

// >>> logic/ohd_top.sv
// sync delay and background meshing for the overlay pixel path
// assumes pixel info arrives on REF_CLK from the character engine
`timescale 1ns/1ps
`include "ohd_defines.svh"
module ohd_top
   import ohd_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic SYS_RST,
   input wire ohd_pkg::ohd_reg_req_t REG_REQ,
   output logic [7:0] REG_RDATA,
   input wire logic HSYNC_IN,
   input wire logic VSYNC_IN,
   input wire ohd_pkg::ohd_pix_t PIX,
   output logic HSYNC_DELAYED,
   output logic FAST_BLANK_OUT,
   output logic [3:0] CELL_DOT,
   output logic [4:0] ROW_LINE
);
   import ohd_pkg::*;
   logic [7:0] hsync_delay_ctrl;
   logic [7:0] overlay_control_reg;
   logic [2:0] hs_sync;
   logic [2:0] vs_sync;
   logic frame_phase;
   logic pix_phase;
   logic line_run;
   logic fire;
   logic [8:0] quiet_cnt;
   // =====================================================
   // register access
   wire logic wr_delay = REG_REQ.wr && (REG_REQ.addr == `OHD_ADDR_HDELAY);
   wire logic wr_ctrl = REG_REQ.wr && (REG_REQ.addr == `OHD_ADDR_OVCTRL);
   wire logic [7:0] rd_mux = (REG_REQ.addr == `OHD_ADDR_HDELAY) ? hsync_delay_ctrl :
      (REG_REQ.addr == `OHD_ADDR_OVCTRL) ? overlay_control_reg : 8'h00;
   always_ff @(posedge REF_CLK)
   begin
      if (SYS_RST)
      begin
         hsync_delay_ctrl <= `OHD_HDELAY_RESET;
         overlay_control_reg <= `OHD_OVCTRL_RESET;
         REG_RDATA <= 8'h00;
      end
      else
      begin
         if (wr_delay)
            hsync_delay_ctrl <= {4'h0, REG_REQ.wdata[3:0]};
         if (wr_ctrl)
            overlay_control_reg <= REG_REQ.wdata;
         REG_RDATA <= rd_mux;
      end
   end
   // =====================================================
   // sync inputs
   // pins are asynchronous, two stages before use
   always_ff @(posedge REF_CLK)
   begin
      if (SYS_RST)
      begin
         hs_sync <= 3'b000;
         vs_sync <= 3'b000;
      end
      else
      begin
         hs_sync <= {hs_sync[1:0], HSYNC_IN};
         vs_sync <= {vs_sync[1:0], VSYNC_IN};
      end
   end
   wire logic hs_edge = hs_sync[1] && !hs_sync[2];
   wire logic vs_edge = vs_sync[1] && !vs_sync[2];
   ohd_delay #(.CODE_W(`OHD_CODE_W)) u_delay
   (
      .clk(REF_CLK),
      .rst(SYS_RST),
      .edge_pulse(hs_edge),
      .code(hsync_delay_ctrl[3:0]),
      .fire(fire)
   );
   // =====================================================
   // cell position counters
   wire logic dot_last = (CELL_DOT == 4'(`OHD_CELL_DOTS - 1));
   wire logic row_last = (ROW_LINE == 5'(`OHD_ROW_LINES - 1));
   always_ff @(posedge REF_CLK)
   begin
      if (SYS_RST)
      begin
         HSYNC_DELAYED <= 1'b0;
         line_run <= 1'b0;
         CELL_DOT <= 4'h0;
         ROW_LINE <= 5'h00;
      end
      else
      begin
         HSYNC_DELAYED <= fire;
         if (vs_edge)
            ROW_LINE <= 5'h00;
         if (fire)
         begin
            line_run <= 1'b1;
            CELL_DOT <= 4'h0;
            if (!vs_edge)
               ROW_LINE <= row_last ? 5'h00 : ROW_LINE + 5'h01;
         end
         else if (line_run)
            CELL_DOT <= dot_last ? 4'h0 : CELL_DOT + 4'h1;
      end
   end
   // =====================================================
   // meshing
   always_ff @(posedge REF_CLK)
   begin
      if (SYS_RST)
      begin
         frame_phase <= 1'b0;
         pix_phase <= 1'b0;
      end
      else
      begin
         if (vs_edge)
            frame_phase <= !frame_phase;
         pix_phase <= fire ? 1'b0 : !pix_phase;
      end
   end
   wire logic mesh_on = overlay_control_reg[`OHD_BIT_MESH_EN] &&
      !overlay_control_reg[`OHD_BIT_FRAME_MODE];
   wire logic bg_pix = PIX.active && PIX.bg_en && !PIX.fg_dot;
   wire logic mesh_dot = !(pix_phase ^ frame_phase);
   wire logic next_fb = PIX.active && (PIX.fg_dot || (bg_pix && (!mesh_on || mesh_dot)));
   always_ff @(posedge REF_CLK)
   begin
      if (SYS_RST)
         FAST_BLANK_OUT <= 1'b0;
      else
         FAST_BLANK_OUT <= next_fb;
   end
   // =====================================================
   // checks
   a_fg_solid: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      PIX.active && PIX.fg_dot |=> FAST_BLANK_OUT)
      else $error("foreground dot not blanked");
   a_frame_mode_solid: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      overlay_control_reg[`OHD_BIT_FRAME_MODE] && bg_pix |=> FAST_BLANK_OUT)
      else $error("meshing in frame mode");
   a_no_bg_off: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      PIX.active && !PIX.bg_en && !PIX.fg_dot |=> !FAST_BLANK_OUT)
      else $error("cell without background blanked");
   a_mesh_toggle: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      mesh_on && bg_pix && !fire && !vs_edge ##1 mesh_on && bg_pix
      |=> FAST_BLANK_OUT != $past(FAST_BLANK_OUT))
      else $error("mesh not toggling per pixel");
   a_mesh_needs_en: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      !overlay_control_reg[`OHD_BIT_MESH_EN] && bg_pix |=> FAST_BLANK_OUT)
      else $error("mesh without enable");
   a_reserved_zero: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      hsync_delay_ctrl[7:4] == 4'h0)
      else $error("reserved delay bits set");
   a_zero_delay: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      hs_edge && hsync_delay_ctrl[3:0] == 4'h0 |=> fire)
      else $error("zero code not immediate");
   // cycles since fire was last high, saturating; stands in for a long repetition
   always_ff @(posedge REF_CLK)
   begin
      if (SYS_RST)
         quiet_cnt <= 9'h000;
      else if (fire)
         quiet_cnt <= 9'h000;
      else if (quiet_cnt != 9'h1ff)
         quiet_cnt <= quiet_cnt + 9'h001;
   end
   a_one_step: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      hs_edge && hsync_delay_ctrl[3:0] == 4'h1 && !wr_delay
      |-> ##33 (fire && quiet_cnt >= 9'h020))
      else $error("code one not 32 dots");
   a_cell_wrap: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      CELL_DOT < 4'(`OHD_CELL_DOTS) && ROW_LINE < 5'(`OHD_ROW_LINES))
      else $error("cell counters out of range");
   c_meshing: cover property (@(posedge REF_CLK) mesh_on && bg_pix);
   c_delay_max: cover property (@(posedge REF_CLK) hs_edge && hsync_delay_ctrl[3:0] == 4'hf);
   c_frame_flip: cover property (@(posedge REF_CLK) vs_edge && frame_phase);
endmodule

// >>> tb/ohd_sync_src.sv
// sync source model: deflection hsync and vsync pulses on request
// assumes go strobes change at the falling edge of clk
`timescale 1ns/1ps
module ohd_sync_src
(
   input wire logic clk,
   input wire logic hs_go,
   input wire logic vs_go,
   output logic hsync = 1'b0,
   output logic vsync = 1'b0
);
   logic [2:0] hc = 3'h0;
   logic [2:0] vc = 3'h0;
   // four dot pulses, far shorter than a line
   always @(posedge clk)
   begin
      hc <= hs_go ? 3'h4 : hc - 3'(hc != 3'h0);
      vc <= vs_go ? 3'h4 : vc - 3'(vc != 3'h0);
   end
   // pins move off the sampling edge
   always @(negedge clk)
   begin
      hsync <= hc != 3'h0;
      vsync <= vc != 3'h0;
   end
endmodule

// >>> tb/osd_hsync_delay_and_meshing_tb.sv
// self-checking bench: registers, sync delay, counters, meshing
// assumes the sync source model and the design package
`timescale 1ns/1ps
module osd_hsync_delay_and_meshing_tb;
   import ohd_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   ohd_reg_req_t req = '0;
   ohd_pix_t pix = '0;
   logic hs_go = 1'b0;
   logic vs_go = 1'b0;
   logic hs, vs, hd, fb;
   logic [7:0] rdata;
   logic [3:0] dot;
   logic [4:0] row;
   int error_cnt = 0;
   int checks = 0;
   int cyc = 0;
   int n0, n;
   logic [7:0] v;
   logic f0;
   logic [7:0] ctl [5] = '{8'h00, 8'h60, 8'h40, 8'h40, 8'h40};
   logic [2:0] px [5] = '{3'h6, 3'h6, 3'h4, 3'h7, 3'h2};
   logic [1:0] ex [5] = '{2'h3, 2'h3, 2'h0, 2'h3, 2'h0};

   initial
      forever
         #50 clk = ~clk;

   ohd_top uut (.REF_CLK(clk), .SYS_RST(rst), .REG_REQ(req), .REG_RDATA(rdata),
      .HSYNC_IN(hs), .VSYNC_IN(vs), .PIX(pix), .HSYNC_DELAYED(hd),
      .FAST_BLANK_OUT(fb), .CELL_DOT(dot), .ROW_LINE(row));
   ohd_sync_src src (.clk(clk), .hs_go(hs_go), .vs_go(vs_go), .hsync(hs), .vsync(vs));

   // ==========================================
   // helpers
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(negedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      tick(1);
      req = '{1'b1, a, d};
      tick(1);
      req.wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      tick(1);
      req = '{1'b0, a, 8'h00};
      tick(1);
      d = rdata;
   endtask
   // count dots from request to the delayed pulse
   task automatic hpulse(output int cnt);
      tick(1);
      hs_go = 1'b1;
      tick(1);
      hs_go = 1'b0;
      cnt = 0;
      while (hd !== 1'b1 && cnt < 600)
      begin
         tick(1);
         cnt++;
      end
   endtask
   task automatic vpulse();
      tick(1);
      vs_go = 1'b1;
      tick(1);
      vs_go = 1'b0;
      tick(8);
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // hang guard, tests need under 5000 cycles
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         error_cnt++;
         close_out();
      end
   end

   // ==========================================
   // tests
   initial
   begin
      tick(10);
      rst = 1'b0;
      rd(8'hc6, v);
      chk(v, 8'h00);
      wr(8'hc6, 8'hf3);
      rd(8'hc6, v);
      chk(v, 8'h03);
      rd(8'h55, v);
      chk(v, 8'h00);
      $display("test regs done");
      wr(8'hc6, 8'h00);
      hpulse(n0);
      // delays stay inside the gap between sync pulses
      for (int c = 1; c < 16; c += 7)
      begin
         wr(8'hc6, 8'(c));
         hpulse(n);
         chk(8'((n - n0) / 32), 8'(c));
         chk(8'((n - n0) % 32), 8'h00);
      end
      $display("test delay done");
      wr(8'hc6, 8'h00);
      hpulse(n);
      tick(1);
      v = 8'(dot);
      repeat (24)
      begin
         tick(1);
         v = (v + 8'h01) % 8'h0c;
         chk(8'(dot), v);
      end
      vpulse();
      chk(8'(row), 8'h00);
      repeat (17) hpulse(n);
      tick(2);
      chk(8'(row), 8'h11);
      hpulse(n);
      tick(2);
      chk(8'(row), 8'h00);
      $display("test counters done");
      pix = 3'h6;
      wr(8'hc0, 8'h40);
      hpulse(n);
      // first dot after the delayed pulse has a known pixel phase
      tick(1);
      f0 = fb;
      tick(1);
      chk(8'(f0 ^ fb), 8'h01);
      vpulse();
      hpulse(n);
      tick(1);
      chk(8'(f0 ^ fb), 8'h01);
      for (int k = 0; k < 5; k++)
      begin
         wr(ctl[k], 8'h00);
         wr(8'hc0, ctl[k]);
         pix = px[k];
         tick(2);
         v[0] = fb;
         tick(1);
         chk({6'h00, v[0], fb}, 8'(ex[k]));
      end
      $display("test meshing done");
      close_out();
   end
endmodule
